// ### src/pps_regs.svh
// Register offsets, reset values, field positions and timing figures for
// the port power and port split block.
// Included by bare name; assumes a 40 MHz core clock.
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH

`define PPS_OFF_LOCKOUT       16'h30e1
`define PPS_OFF_SPLIT_PORT    16'h3c48
`define PPS_OFF_SPLIT_GLOBAL  16'h4141
`define PPS_OFF_P4_SELECT     16'h416e
`define PPS_OFF_P5_SELECT     16'h416f
`define PPS_OFF_LINK_TIMEOUT  16'h4171
`define PPS_OFF_TOGGLE_TIME   16'h4176

`define PPS_RST_LOCKOUT       8'h0a
`define PPS_RST_SPLIT_PORT    8'h00
`define PPS_RST_SPLIT_GLOBAL  8'h00
`define PPS_RST_P4_SELECT     8'h42
`define PPS_RST_P5_SELECT     8'h06
`define PPS_RST_LINK_TIMEOUT  8'h05
`define PPS_RST_TOGGLE_TIME   8'h05

`define PPS_BIT_GLOBAL        0
`define PPS_BIT_P4_SPLIT      5
`define PPS_BIT_P5_SPLIT      6
`define PPS_MASK_SPLIT_PORT   8'h60
`define PPS_MASK_GLOBAL       8'h01
`define PPS_MASK_TIMEOUT      8'h07

`define PPS_P4_SEL_A          8'h42
`define PPS_P4_SEL_B          8'h05
`define PPS_P5_SEL_A          8'h06
`define PPS_P5_SEL_B          8'h04

`define PPS_LINK_BAD_FIRST    4'h4
`define PPS_LINK_BAD_LAST     4'h9

`define PPS_CLK_HZ            40000000
`define PPS_TICK_MS           1
`define PPS_TIMEOUT_C1_MS     11'h064
`define PPS_TIMEOUT_C2_MS     11'h0fa
`define PPS_TIMEOUT_C3_MS     11'h1f4
`define PPS_TIMEOUT_C4_MS     11'h2ee
`define PPS_TIMEOUT_C5_MS     11'h3e8
`define PPS_TIMEOUT_C6_MS     11'h7d0
`define PPS_TOGGLE_BASE_MS    12'h15e
`define PPS_TOGGLE_STEP_MS    12'h00a

`endif

// ### src/pps_pkg.sv
// Types shared by the port power and port split modules.
// Assumes nothing of its surroundings.
`default_nettype none

package pps_pkg;

    typedef struct packed {
        logic        write;
        logic        read;
        logic        fromOtp;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pps_cfg_req_type;

    typedef struct packed {
        logic        enable;
        logic [10:0] timeoutMs;
        logic [11:0] toggleMs;
    } pps_split_cfg_type;

    typedef enum logic [1:0] {
        SPLIT_OFF   = 2'h0,
        SPLIT_WATCH = 2'h1,
        SPLIT_LOW   = 2'h2
    } pps_split_state_type;

    typedef enum logic [2:0] {
        REG_NONE         = 3'h0,
        REG_LOCKOUT      = 3'h1,
        REG_SPLIT_PORT   = 3'h2,
        REG_SPLIT_GLOBAL = 3'h3,
        REG_P4_SELECT    = 3'h4,
        REG_P5_SELECT    = 3'h5,
        REG_LINK_TIMEOUT = 3'h6,
        REG_TOGGLE_TIME  = 3'h7
    } pps_reg_sel_type;

endpackage

`default_nettype wire

// ### src/pps_ms_tick.sv
// Millisecond tick generator for all block timers.
// Assumes CYCLES core clock periods make one millisecond.
`timescale 1ns/1ps
`default_nettype none

module pps_ms_tick #(
    parameter int CYCLES = 40000
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Tick
    output logic      msTick
);

    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] count_reg;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= '0;
            msTick    <= 1'b0;
        end
        else if (count_reg == W'(CYCLES - 1))
        begin
            count_reg <= '0;
            msTick    <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
            msTick    <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### src/pps_split_port.sv
// Link watchdog and power pin sequencer for one split port.
// Assumes the link state comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.svh"

module pps_split_port (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // Timing and configuration
    input  wire logic                       msTick,
    input  wire pps_pkg::pps_split_cfg_type cfg,
    input  wire logic [3:0]                 linkState,
    // Pin control
    output logic                            pinHigh,
    output logic                            pulsing
);

    pps_pkg::pps_split_state_type state_reg;
    logic [3:0]                   held_reg;
    logic [10:0]                  stuck_reg;
    logic [11:0]                  low_reg;

    function automatic logic linkBad(input logic [3:0] ls);
        linkBad = ls >= `PPS_LINK_BAD_FIRST && ls <= `PPS_LINK_BAD_LAST;
    endfunction

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= pps_pkg::SPLIT_OFF;
            held_reg  <= 4'h0;
            stuck_reg <= 11'h000;
            low_reg   <= 12'h000;
        end
        else
        begin
            held_reg <= linkState;
            unique case (state_reg)
                pps_pkg::SPLIT_OFF:
                begin
                    stuck_reg <= 11'h000;
                    if (cfg.enable)
                        state_reg <= pps_pkg::SPLIT_WATCH;
                end
                pps_pkg::SPLIT_WATCH:
                begin
                    // A change of state, even between bad ones, restarts
                    if (!cfg.enable)
                        state_reg <= pps_pkg::SPLIT_OFF;
                    else if (cfg.timeoutMs == 11'h000 ||
                             !linkBad(linkState) ||
                             linkState != held_reg)
                        stuck_reg <= 11'h000;
                    else if (msTick)
                    begin
                        if (11'(stuck_reg + 11'h001) >= cfg.timeoutMs)
                        begin
                            state_reg <= pps_pkg::SPLIT_LOW;
                            low_reg   <= cfg.toggleMs;
                            stuck_reg <= 11'h000;
                        end
                        else
                            stuck_reg <= 11'(stuck_reg + 11'h001);
                    end
                end
                pps_pkg::SPLIT_LOW:
                begin
                    if (!cfg.enable)
                        state_reg <= pps_pkg::SPLIT_OFF;
                    else if (msTick)
                    begin
                        if (low_reg <= 12'h001)
                            state_reg <= pps_pkg::SPLIT_WATCH;
                        else
                            low_reg <= 12'(low_reg - 12'h001);
                    end
                end
                default:
                    state_reg <= pps_pkg::SPLIT_OFF;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pinHigh <= 1'b0;
            pulsing <= 1'b0;
        end
        else
        begin
            pinHigh <= state_reg == pps_pkg::SPLIT_WATCH;
            pulsing <= state_reg == pps_pkg::SPLIT_LOW;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_good_link_clears:
    assert property (state_reg == pps_pkg::SPLIT_WATCH && cfg.enable &&
                     !linkBad(linkState) |=> stuck_reg == 11'h000)
        else $error("Stuck timer ran with a valid link");

    a_zero_never_pulses:
    assert property (cfg.timeoutMs == 11'h000 &&
                     state_reg == pps_pkg::SPLIT_WATCH
                     |=> state_reg != pps_pkg::SPLIT_LOW)
        else $error("Pulse started with timeout disabled");

    a_low_time_loaded:
    assert property (state_reg == pps_pkg::SPLIT_WATCH
                     ##1 state_reg == pps_pkg::SPLIT_LOW
                     |-> low_reg == $past(cfg.toggleMs))
        else $error("Low time not loaded from toggle time");

    a_pulse_holds_low:
    assert property (pulsing |-> !pinHigh)
        else $error("Split pin high during link reset pulse");

endmodule

`default_nettype wire

// ### src/pps_top.sv
// Downstream port power pins with overcurrent lockout, and the SuperSpeed
// split power pins for ports 4 and 5 with their stuck-link watchdog.
// Assumes one core clock, configuration writes from SMBus during the
// configuration stage or from OTP through one shared access port, and
// link states and power requests from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.svh"

module pps_top #(
    parameter int NUM_PORTS = 5,
    parameter int MS_CYCLES = `PPS_CLK_HZ / 1000 * `PPS_TICK_MS
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // Configuration access
    input  wire pps_pkg::pps_cfg_req_type cfgReq,
    input  wire logic                     cfgStage,
    output logic [7:0]                    cfgRdata,
    output logic                          cfgRvalid,
    // Port power and sense pins
    input  wire logic [NUM_PORTS-1:0]     portPowerOn,
    input  wire logic [NUM_PORTS-1:0]     senseIn,
    output logic [NUM_PORTS-1:0]          senseOut,
    output logic [NUM_PORTS-1:0]          senseOe,
    output logic [NUM_PORTS-1:0]          pullupEn,
    output logic [NUM_PORTS-1:0]          overcurrent,
    // Split ports 4 and 5
    input  wire logic [1:0][3:0]          linkStateStatus,
    output logic [3:0]                    splitGpioOut,
    output logic [3:0]                    splitGpioOe,
    output logic [1:0]                    splitResetActive
);

    logic [NUM_PORTS-1:0]      senseMeta_reg;
    logic [NUM_PORTS-1:0]      senseSync_reg;
    logic [NUM_PORTS-1:0]      powerPrev_reg;
    logic [NUM_PORTS-1:0][7:0] lockCnt_reg;
    logic [7:0]                lockoutCfg_reg;
    logic [7:0]                splitPort_reg;
    logic [7:0]                splitGlobal_reg;
    logic [7:0]                p4Select_reg;
    logic [7:0]                p5Select_reg;
    logic [7:0]                timeout_reg;
    logic [7:0]                toggle_reg;
    logic                      msTick;
    logic                      wrOk;
    pps_pkg::pps_reg_sel_type  wrSel;
    pps_pkg::pps_reg_sel_type  rdSel;
    logic [7:0]                rdMux;
    logic [11:0]               toggleMs;
    logic [1:0]                splitEn;
    logic [1:0][1:0]           pinSel;
    logic [1:0]                splitPinHigh;

    function automatic pps_pkg::pps_reg_sel_type decodeReg(
        input logic [15:0] addr
    );
        case (addr)
            `PPS_OFF_LOCKOUT:      decodeReg = pps_pkg::REG_LOCKOUT;
            `PPS_OFF_SPLIT_PORT:   decodeReg = pps_pkg::REG_SPLIT_PORT;
            `PPS_OFF_SPLIT_GLOBAL: decodeReg = pps_pkg::REG_SPLIT_GLOBAL;
            `PPS_OFF_P4_SELECT:    decodeReg = pps_pkg::REG_P4_SELECT;
            `PPS_OFF_P5_SELECT:    decodeReg = pps_pkg::REG_P5_SELECT;
            `PPS_OFF_LINK_TIMEOUT: decodeReg = pps_pkg::REG_LINK_TIMEOUT;
            `PPS_OFF_TOGGLE_TIME:  decodeReg = pps_pkg::REG_TOGGLE_TIME;
            default:               decodeReg = pps_pkg::REG_NONE;
        endcase
    endfunction

    function automatic logic [10:0] timeoutMs(input logic [2:0] code);
        case (code)
            3'h1:    timeoutMs = `PPS_TIMEOUT_C1_MS;
            3'h2:    timeoutMs = `PPS_TIMEOUT_C2_MS;
            3'h3:    timeoutMs = `PPS_TIMEOUT_C3_MS;
            3'h4:    timeoutMs = `PPS_TIMEOUT_C4_MS;
            3'h5:    timeoutMs = `PPS_TIMEOUT_C5_MS;
            3'h6:    timeoutMs = `PPS_TIMEOUT_C6_MS;
            // Code 0 disables; reserved code 7 is treated the same way
            default: timeoutMs = 11'h000;
        endcase
    endfunction

    // Bit 0 is option A, bit 1 option B; an unknown code drives no pin
    function automatic logic [1:0] selectOption(
        input logic [7:0] code,
        input logic [7:0] codeA,
        input logic [7:0] codeB
    );
        selectOption = {code == codeB, code == codeA};
    endfunction

    pps_ms_tick #(
        .CYCLES (MS_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .rst     (rst),
        .msTick  (msTick)
    );

    // Configuration registers
    assign wrSel = decodeReg(cfgReq.addr);
    assign rdSel = decodeReg(cfgReq.addr);
    assign wrOk  = cfgReq.write && (cfgReq.fromOtp || cfgStage);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            lockoutCfg_reg  <= `PPS_RST_LOCKOUT;
            splitPort_reg   <= `PPS_RST_SPLIT_PORT;
            splitGlobal_reg <= `PPS_RST_SPLIT_GLOBAL;
            p4Select_reg    <= `PPS_RST_P4_SELECT;
            p5Select_reg    <= `PPS_RST_P5_SELECT;
            timeout_reg     <= `PPS_RST_LINK_TIMEOUT;
            toggle_reg      <= `PPS_RST_TOGGLE_TIME;
        end
        else if (wrOk)
        begin
            unique case (wrSel)
                pps_pkg::REG_NONE:
                    ;
                pps_pkg::REG_LOCKOUT:
                    lockoutCfg_reg <= cfgReq.wdata;
                pps_pkg::REG_SPLIT_PORT:
                    splitPort_reg <= cfgReq.wdata &
                                     `PPS_MASK_SPLIT_PORT;
                pps_pkg::REG_SPLIT_GLOBAL:
                    splitGlobal_reg <= cfgReq.wdata &
                                       `PPS_MASK_GLOBAL;
                pps_pkg::REG_P4_SELECT:
                    p4Select_reg <= cfgReq.wdata;
                pps_pkg::REG_P5_SELECT:
                    p5Select_reg <= cfgReq.wdata;
                pps_pkg::REG_LINK_TIMEOUT:
                    timeout_reg <= cfgReq.wdata &
                                   `PPS_MASK_TIMEOUT;
                pps_pkg::REG_TOGGLE_TIME:
                    toggle_reg <= cfgReq.wdata;
            endcase
        end
    end

    always_comb
    begin
        unique case (rdSel)
            pps_pkg::REG_NONE:         rdMux = 8'h00;
            pps_pkg::REG_LOCKOUT:      rdMux = lockoutCfg_reg;
            pps_pkg::REG_SPLIT_PORT:   rdMux = splitPort_reg;
            pps_pkg::REG_SPLIT_GLOBAL: rdMux = splitGlobal_reg;
            pps_pkg::REG_P4_SELECT:    rdMux = p4Select_reg;
            pps_pkg::REG_P5_SELECT:    rdMux = p5Select_reg;
            pps_pkg::REG_LINK_TIMEOUT: rdMux = timeout_reg;
            pps_pkg::REG_TOGGLE_TIME:  rdMux = toggle_reg;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cfgRdata  <= 8'h00;
            cfgRvalid <= 1'b0;
        end
        else
        begin
            cfgRvalid <= cfgReq.read;
            if (cfgReq.read)
                cfgRdata <= rdMux;
        end
    end

    // Pin samples pass two flip-flops before anything looks at them
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            senseMeta_reg <= '1;
            senseSync_reg <= '1;
            powerPrev_reg <= '0;
        end
        else
        begin
            senseMeta_reg <= senseIn;
            senseSync_reg <= senseMeta_reg;
            powerPrev_reg <= portPowerOn;
        end
    end

    // Pin drive; the pull-up is off while driving low to save power
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            senseOut <= '0;
            senseOe  <= '1;
            pullupEn <= '0;
        end
        else
        begin
            senseOut <= '0;
            senseOe  <= ~portPowerOn;
            pullupEn <= portPowerOn;
        end
    end

    // Lockout and overcurrent; the first millisecond may be short by
    // up to one tick since the tick runs free
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            lockCnt_reg <= '0;
            overcurrent <= '0;
        end
        else
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (portPowerOn[p] && !powerPrev_reg[p])
                    lockCnt_reg[p] <= lockoutCfg_reg;
                else if (!portPowerOn[p])
                    lockCnt_reg[p] <= 8'h00;
                else if (msTick && lockCnt_reg[p] != 8'h00)
                    lockCnt_reg[p] <= lockCnt_reg[p] - 8'h01;
                overcurrent[p] <= portPowerOn[p] && powerPrev_reg[p] &&
                                  lockCnt_reg[p] == 8'h00 &&
                                  !senseSync_reg[p];
            end
        end
    end

    // Split ports; the power sense pin above is untouched by splitting
    assign toggleMs = `PPS_TOGGLE_BASE_MS +
                      12'(toggle_reg) * `PPS_TOGGLE_STEP_MS;
    assign splitEn  = {2{splitGlobal_reg[`PPS_BIT_GLOBAL]}} &
                      splitPort_reg[`PPS_BIT_P5_SPLIT:`PPS_BIT_P4_SPLIT];
    assign pinSel[0] = selectOption(p4Select_reg, `PPS_P4_SEL_A,
                                    `PPS_P4_SEL_B);
    assign pinSel[1] = selectOption(p5Select_reg, `PPS_P5_SEL_A,
                                    `PPS_P5_SEL_B);

    generate
        for (genvar s = 0; s < 2; s++)
        begin : g_split
            pps_pkg::pps_split_cfg_type splitCfg;

            assign splitCfg.enable    = splitEn[s];
            assign splitCfg.timeoutMs = timeoutMs(timeout_reg[2:0]);
            assign splitCfg.toggleMs  = toggleMs;

            pps_split_port u_split (
                .sys_clk   (sys_clk),
                .rst       (rst),
                .msTick    (msTick),
                .cfg       (splitCfg),
                .linkState (linkStateStatus[s]),
                .pinHigh   (splitPinHigh[s]),
                .pulsing   (splitResetActive[s])
            );
        end
    endgenerate

    // Split pins are drive only: nothing is sampled back from them
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            splitGpioOut <= 4'h0;
            splitGpioOe  <= 4'h0;
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                for (int o = 0; o < 2; o++)
                begin
                    splitGpioOe[2*s+o]  <= splitEn[s] && pinSel[s][o];
                    splitGpioOut[2*s+o] <= splitPinHigh[s];
                end
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_off_drives_low:
    assert property (!portPowerOn[0] |=> senseOe[0] && !senseOut[0] &&
                     !pullupEn[0])
        else $error("Unpowered port pin not driven low");

    a_on_releases_pin:
    assert property (portPowerOn[NUM_PORTS-1] |=>
                     !senseOe[NUM_PORTS-1] && pullupEn[NUM_PORTS-1])
        else $error("Powered port pin not released with pull-up");

    a_lockout_loads:
    assert property ($rose(portPowerOn[0]) |=>
                     lockCnt_reg[0] == $past(lockoutCfg_reg))
        else $error("Lockout count not loaded at power-on");

    a_lockout_blinds:
    assert property (lockCnt_reg[0] != 8'h00 |=> !overcurrent[0])
        else $error("Overcurrent flagged inside lockout");

    a_low_is_overcurrent:
    assert property (portPowerOn[0] && powerPrev_reg[0] &&
                     lockCnt_reg[0] == 8'h00 && !senseSync_reg[0]
                     |=> overcurrent[0])
        else $error("Low sense while powered not flagged");

    a_split_needs_global:
    assert property (!splitGlobal_reg[`PPS_BIT_GLOBAL] |=>
                     splitGpioOe == 4'h0)
        else $error("Split pin driven without global enable");

    a_cfg_write_gate:
    assert property (cfgReq.write && !cfgReq.fromOtp && !cfgStage |=>
                     $stable(splitGlobal_reg) && $stable(splitPort_reg) &&
                     $stable(timeout_reg))
        else $error("Split setting changed outside configuration");

    a_port_reserved_zero:
    assert property (cfgReq.read && cfgReq.addr == `PPS_OFF_SPLIT_PORT
                     |=> cfgRvalid &&
                     (cfgRdata & ~`PPS_MASK_SPLIT_PORT) == 8'h00)
        else $error("Reserved split enable bits read nonzero");

    a_timeout_upper_zero:
    assert property (cfgReq.read && cfgReq.addr == `PPS_OFF_LINK_TIMEOUT
                     |=> cfgRdata[7:3] == 5'h00)
        else $error("Timeout register upper bits read nonzero");

    a_bad_select_idle:
    assert property (pinSel[0] == 2'h0 |=> splitGpioOe[1:0] == 2'h0)
        else $error("Split pin driven with unknown select code");

    a_pulse_pin_low:
    assert property (splitResetActive[0] |=> splitGpioOut[1:0] == 2'h0)
        else $error("Split pin high during link reset pulse");

    c_overcurrent_seen:
    cover property ($rose(overcurrent[0]));

    c_split_pulse:
    cover property ($rose(splitResetActive[0]));

    c_otp_write:
    cover property (cfgReq.write && cfgReq.fromOtp && !cfgStage);

endmodule

`default_nettype wire

// ### sim/pps_far_side.sv
// Port power switch model on the combined power and sense pins.
// Assumes the hub pin drives low when its output enable is high.
`timescale 1ns/1ps
`default_nettype none

module pps_far_side (
    // Hub side
    input  wire logic [4:0] senseOe,
    input  wire logic [4:0] pullupEn,
    // Fault request
    input  wire logic [4:0] fault,
    // Pin level
    output logic      [4:0] pin
);
    // A pin with no pull-up and no driver floats; model it as low
    // Power is good at once, as with zero power-good descriptors
    assign pin = ~senseOe & pullupEn & ~fault;
endmodule

`default_nettype wire

// ### sim/testbench.sv
// Random and corner tests of the port power and split block.
// Assumes a shortened millisecond tick of four clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.svh"

module testbench;
    logic                     sys_clk = 0, rst = 1, cfgStage = 1, cfgRvalid;
    pps_pkg::pps_cfg_req_type cfgReq = '0;
    logic [4:0]               portPowerOn = '0, fault = '0, senseIn;
    logic [4:0]               senseOut, senseOe, pullupEn, overcurrent;
    logic [1:0][3:0]          linkStateStatus = '0;
    logic [7:0]               cfgRdata, rd;
    logic [3:0]               splitGpioOut, splitGpioOe;
    logic [1:0]               splitResetActive;
    int                       failures = 0, n_tests = 0, seed = 32'h3272;
    int                       i, p;

    pps_top #(.MS_CYCLES(4)) i_pps_top (.sys_clk(sys_clk), .rst(rst),
        .cfgReq(cfgReq), .cfgStage(cfgStage), .cfgRdata(cfgRdata),
        .cfgRvalid(cfgRvalid), .portPowerOn(portPowerOn), .senseIn(senseIn),
        .senseOut(senseOut), .senseOe(senseOe), .pullupEn(pullupEn),
        .overcurrent(overcurrent), .linkStateStatus(linkStateStatus),
        .splitGpioOut(splitGpioOut), .splitGpioOe(splitGpioOe),
        .splitResetActive(splitResetActive));
    pps_far_side i_pps_far_side (.senseOe(senseOe), .pullupEn(pullupEn),
        .fault(fault), .pin(senseIn));

    initial
        forever #12.5 sys_clk = ~sys_clk;

    task automatic test_done;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d, logic otp = 0);
        @(posedge sys_clk);
        cfgReq <= '{1'b1, 1'b0, otp, a, d};
        @(posedge sys_clk);
        cfgReq <= '0;
    endtask

    task automatic rdchk(string n, logic [15:0] a, logic [7:0] e);
        @(posedge sys_clk);
        cfgReq <= '{1'b0, 1'b1, 1'b0, a, 8'h00};
        @(posedge sys_clk);
        cfgReq <= '0;
        // Valid stands only in the cycle after the strobe edge
        #1;
        cmp("rvalid", 1, cfgRvalid);
        cmp(n, e, cfgRdata);
    endtask

    // Bounded wait on the port 4 reset pulse; i holds cycles waited
    task automatic waitRa(logic v, int lim);
        for (i = 0; i < lim && splitResetActive[0] !== v; i++)
            @(posedge sys_clk) #1;
        if (i == lim)
        begin
            failures++;
            test_done();
        end
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        rdchk("lockout", `PPS_OFF_LOCKOUT, 8'h0a);
        rdchk("timeout", `PPS_OFF_LINK_TIMEOUT, 8'h05);
        rdchk("unmapped", 16'h1234, 8'h00);
        wr(`PPS_OFF_SPLIT_PORT, 8'hff);
        rdchk("split port", `PPS_OFF_SPLIT_PORT, 8'h60);
        cfgStage <= 0;
        wr(`PPS_OFF_SPLIT_GLOBAL, 8'h01);
        rdchk("late write", `PPS_OFF_SPLIT_GLOBAL, 8'h00);
        wr(`PPS_OFF_SPLIT_GLOBAL, 8'hff, 1);
        rdchk("otp write", `PPS_OFF_SPLIT_GLOBAL, 8'h01);
        cfgStage <= 1;
        $display("test registers done");
        rd = 8'(($random(seed) & 7) + 2);
        p = ($random(seed) & 32'h7fffffff) % 5;
        wr(`PPS_OFF_LOCKOUT, rd);
        rdchk("lockout", `PPS_OFF_LOCKOUT, rd);
        // Port 0 always faults so its assertions see a trip; p is random
        fault <= 5'(1 << p) | 5'h01;
        portPowerOn <= 5'h1f;
        repeat (2) @(posedge sys_clk) #1;
        cmp("oe on", 0, senseOe);
        cmp("pullup", 8'h1f, pullupEn);
        repeat (4 * rd - 4) @(posedge sys_clk) #1;
        cmp("oc locked", 0, overcurrent);
        repeat (10) @(posedge sys_clk) #1;
        cmp("oc", fault, overcurrent);
        portPowerOn <= '0;
        repeat (2) @(posedge sys_clk) #1;
        cmp("oe off", 8'h1f, senseOe);
        cmp("pullup off", 0, pullupEn);
        cmp("out low", 0, senseOut);
        cmp("oc off", 0, overcurrent);
        $display("test power done");
        wr(`PPS_OFF_LINK_TIMEOUT, 8'h01);
        wr(`PPS_OFF_TOGGLE_TIME, 8'h00);
        wr(`PPS_OFF_P4_SELECT, 8'h05);
        repeat (4) @(posedge sys_clk) #1;
        cmp("split oe", 4'b0110, splitGpioOe);
        cmp("pin high", 1, splitGpioOut[1]);
        linkStateStatus[0] <= 4'h5;
        waitRa(1, 420);
        cmp("timeout", 1, i > 395 && i < 405);
        repeat (2) @(posedge sys_clk) #1;
        cmp("pin low", 0, splitGpioOut[1]);
        waitRa(0, 1420);
        cmp("low time", 1, i > 1393 && i < 1402);
        repeat (2) @(posedge sys_clk) #1;
        cmp("pin back", 1, splitGpioOut[1]);
        waitRa(1, 420);
        cmp("restart", 1, i > 395 && i < 405);
        cmp("p5 idle", 0, splitResetActive[1]);
        wr(`PPS_OFF_P4_SELECT, 8'h33);
        wr(`PPS_OFF_P5_SELECT, 8'h04);
        wr(`PPS_OFF_LINK_TIMEOUT, 8'h00);
        repeat (2) @(posedge sys_clk) #1;
        cmp("bad select", 4'b1000, splitGpioOe);
        waitRa(0, 1420);
        repeat (450) @(posedge sys_clk) #1;
        cmp("no pulse", 0, splitResetActive[0]);
        $display("test split done");
        test_done();
    end
endmodule

`default_nettype wire
